// ==== rtl/tmc_pkg.sv ====
// Shared constants and types of the touch measurement configuration block.
// Assumes a single 10 MHz core clock; the 2 MHz measurement oscillator is
// modelled as a fixed number of core cycles per oscillator period.
package tmc_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int unsigned CORE_CLK_HZ     = 10_000_000;
	localparam int unsigned OSC_HZ          = 2_000_000;
	localparam int unsigned CYC_PER_OSC     = CORE_CLK_HZ / OSC_HZ;
	localparam int unsigned CYC_PER_US      = CORE_CLK_HZ / 1_000_000;
	localparam int unsigned MIN_ADC_SETTLE_US = 10;
	// Acquisition lengths in oscillator periods for codes 00..11
	localparam int unsigned ACQ_OSC_PERIODS [4] = '{4, 16, 64, 256};
	// Settle ladder in microseconds for codes 0000..1111
	localparam int unsigned SETTLE_LADDER_US [16] = '{
		10, 20, 50, 80, 100, 200, 500, 800,
		1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};
	// Panel setup code that skips the setup interval
	localparam logic [3:0] PANEL_SKIP_CODE = 4'h0;

	// ************************************************************
	// Register offsets and reset values
	// ************************************************************
	localparam logic [7:0] MEASUREMENT_RESOLUTION_OFS    = 8'h02;
	localparam logic [7:0] MEASUREMENT_AVERAGING_OFS     = 8'h03;
	localparam logic [7:0] ADC_SAMPLING_TIME_OFS         = 8'h04;
	localparam logic [7:0] PANEL_SETUP_TIMING_OFS        = 8'h05;
	localparam logic [7:0] DELAYED_CONVERSION_TIMING_OFS = 8'h06;
	localparam logic [7:0] MEASUREMENT_RESOLUTION_RST    = 8'h00;
	localparam logic [7:0] MEASUREMENT_AVERAGING_RST     = 8'h00;
	localparam logic [7:0] ADC_SAMPLING_TIME_RST         = 8'h00;
	localparam logic [7:0] PANEL_SETUP_TIMING_RST        = 8'h00;
	localparam logic [7:0] DELAYED_CONVERSION_TIMING_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_READ                 = 8'h00;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam logic [7:0] RESOLUTION_IMPL_MASK        = 8'h1F;
	localparam int unsigned ADC_LOW_POWER_SELECT_BIT   = 4;
	localparam int unsigned X_RESOLUTION_SELECT_BIT    = 3;
	localparam int unsigned Y_RESOLUTION_SELECT_BIT    = 2;
	localparam int unsigned Z1_RESOLUTION_SELECT_BIT   = 1;
	localparam int unsigned Z2_RESOLUTION_SELECT_BIT   = 0;
	localparam int unsigned X_AVERAGE_DEPTH_LSB        = 6;
	localparam int unsigned Y_AVERAGE_DEPTH_LSB        = 4;
	localparam int unsigned Z1_AVERAGE_DEPTH_LSB       = 2;
	localparam int unsigned Z2_AVERAGE_DEPTH_LSB       = 0;
	localparam int unsigned X_ACQUIRE_TIME_LSB         = 6;
	localparam int unsigned Y_ACQUIRE_TIME_LSB         = 4;
	localparam int unsigned Z1_ACQUIRE_TIME_LSB        = 2;
	localparam int unsigned Z2_ACQUIRE_TIME_LSB        = 0;
	localparam int unsigned POSITION_SETTLE_LSB        = 4;
	localparam int unsigned PRESSURE_SETTLE_LSB        = 0;

	// ************************************************************
	// Types
	// ************************************************************
	localparam int unsigned SAMPLE_W  = 12;
	localparam int unsigned MAX_DEPTH = 16;

	typedef enum logic [1:0] {
		TMC_CH_X,
		TMC_CH_Y,
		TMC_CH_Z1,
		TMC_CH_Z2
	} tmc_channel_e;

	typedef enum logic [2:0] {
		TMC_ST_IDLE,
		TMC_ST_PANEL_SETUP,
		TMC_ST_ADC_SETTLE,
		TMC_ST_ACQUIRE,
		TMC_ST_CONVERT,
		TMC_ST_REDUCE
	} tmc_state_e;

	// Register access from the serial interface decoder
	typedef struct packed {
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tmc_reg_req_s;

	// Controls toward the panel switches and the ADC
	typedef struct packed {
		logic panel_drive;
		logic adc_powered;
		logic adc_acquire;
		logic adc_convert;
		logic adc_eight_bit;
		logic adc_low_power_select;
	} tmc_adc_ctl_s;

	// One finished measurement
	typedef struct packed {
		logic                valid;
		tmc_channel_e        channel;
		logic [SAMPLE_W-1:0] value;
	} tmc_result_s;

endpackage : tmc_pkg

// ==== rtl/tmc_interval_timer.sv ====
// Down-counting interval timer used for the panel setup, ADC settle and acquire phases of a measurement.
// Assumes the caller loads a count of at least one cycle.
`timescale 1ns/1ps
`default_nettype none

module tmc_interval_timer #(
	parameter int unsigned WIDTH = 22
) (
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_count,
	output logic                  expired
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic             running;
		logic [WIDTH-1:0] count;
	} tmc_timer_s;

	tmc_timer_s state;
	tmc_timer_s next_state;

	// Refuse a counter too narrow to hold a count down to one
	if (WIDTH < 2)
	begin : g_bad_width
		$error("tmc_interval_timer: WIDTH too small");
	end

	// Last cycle of the interval; kept free of load so that a caller that
	// reloads on expiry forms no combinational loop through this output
	assign expired = state.running && (state.count == WIDTH'(1));

	// Count down, stop at the last cycle
	always_comb
	begin
		next_state = state;
		if (load)
		begin
			next_state.running = 1'b1;
			next_state.count   = load_count;
		end
		else if (state.running)
		begin
			next_state.count = state.count - WIDTH'(1);
			if (state.count == WIDTH'(1))
				next_state.running = 1'b0;
		end
	end

	// Register the copy
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			state <= '0;
		else
			state <= next_state;
	end

endmodule : tmc_interval_timer

`default_nettype wire

// ==== rtl/tmc_measure_seq.sv ====
// Measurement configuration registers and phase sequencer of the touch
// controller: settle intervals, acquisition, conversion and averaging.
// Assumes a command decoder issues meas_start and an ADC on core_clk that
// answers each conversion with adc_conv_done and a sample.
`timescale 1ns/1ps
`default_nettype none

module tmc_measure_seq #(
	parameter int unsigned CYCLES_PER_US = tmc_pkg::CYC_PER_US,
	parameter int unsigned TMR_W         = 22
) (
	input  wire logic                         core_clk,
	input  wire logic                         rst_b,
	input  wire tmc_pkg::tmc_reg_req_s        reg_req,
	output logic [7:0]                        reg_rdata,
	input  wire logic                         meas_start,
	input  wire tmc_pkg::tmc_channel_e        meas_channel,
	input  wire logic                         averaging_enable,
	input  wire logic                         averaging_filter_select,
	input  wire logic                         adc_conv_done,
	input  wire logic [tmc_pkg::SAMPLE_W-1:0] adc_sample,
	output tmc_pkg::tmc_adc_ctl_s             adc_ctl,
	output logic                              meas_busy,
	output tmc_pkg::tmc_result_s              result
);

	localparam int unsigned SW = tmc_pkg::SAMPLE_W;
	localparam int unsigned MD = tmc_pkg::MAX_DEPTH;

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		tmc_pkg::tmc_state_e      phase;
		tmc_pkg::tmc_channel_e    channel;
		logic                     mean_mode;
		logic [1:0]               depth_code;
		logic [1:0]               acq_code;
		logic [4:0]               taken;
		logic [MD-1:0][SW-1:0]    sorted;
		logic [7:0]               resolution;
		logic [7:0]               averaging;
		logic [7:0]               sampling;
		logic [7:0]               panel_setup;
		logic [7:0]               delayed_conv;
		logic [7:0]               rdata;
		tmc_pkg::tmc_result_s     result;
	} tmc_seq_s;

	tmc_seq_s state;
	tmc_seq_s next_state;

	logic             tmr_load;
	logic [TMR_W-1:0] tmr_count;
	logic             tmr_expired;

	// Refuse a rate whose longest settle interval overflows the timer
	if (CYCLES_PER_US < 1 || 64'(CYCLES_PER_US) * 64'd200000 >= (64'd1 << TMR_W))
	begin : g_bad_rate
		$error("tmc_measure_seq: CYCLES_PER_US does not fit TMR_W");
	end

	// ************************************************************
	// Helpers
	// ************************************************************
	// Settle ladder code to cycles, never below one cycle
	function automatic logic [TMR_W-1:0] ladder_cycles(input logic [3:0] code);
		logic [63:0] cyc;
		cyc = 64'(tmc_pkg::SETTLE_LADDER_US[code]) * 64'(CYCLES_PER_US);
		return TMR_W'(cyc);
	endfunction : ladder_cycles

	// Acquisition code to cycles of the core clock
	function automatic logic [TMR_W-1:0] acquire_cycles(input logic [1:0] code);
		logic [63:0] cyc;
		cyc = 64'(tmc_pkg::ACQ_OSC_PERIODS[code]) * 64'(tmc_pkg::CYC_PER_OSC);
		return TMR_W'(cyc);
	endfunction : acquire_cycles

	// Two-bit field of a register for one channel
	function automatic logic [1:0] chan_field(input logic [7:0] r,
		input tmc_pkg::tmc_channel_e ch);
		logic [1:0] f;
		unique case (ch)
			tmc_pkg::TMC_CH_X:  f = r[tmc_pkg::X_AVERAGE_DEPTH_LSB +: 2];
			tmc_pkg::TMC_CH_Y:  f = r[tmc_pkg::Y_AVERAGE_DEPTH_LSB +: 2];
			tmc_pkg::TMC_CH_Z1: f = r[tmc_pkg::Z1_AVERAGE_DEPTH_LSB +: 2];
			tmc_pkg::TMC_CH_Z2: f = r[tmc_pkg::Z2_AVERAGE_DEPTH_LSB +: 2];
		endcase
		return f;
	endfunction : chan_field

	// Settle nibble: position for X/Y, pressure for Z1/Z2
	function automatic logic [3:0] settle_code(input logic [7:0] r,
		input tmc_pkg::tmc_channel_e ch);
		logic pos;
		pos = (ch == tmc_pkg::TMC_CH_X) || (ch == tmc_pkg::TMC_CH_Y);
		return pos ? r[tmc_pkg::POSITION_SETTLE_LSB +: 4] :
			r[tmc_pkg::PRESSURE_SETTLE_LSB +: 4];
	endfunction : settle_code

	// Samples per run: 1, 4, 8 or 16
	function automatic logic [4:0] depth_total(input logic [1:0] code);
		return (code == 2'h0) ? 5'h01 : (5'h02 << code);
	endfunction : depth_total

	// ************************************************************
	// Phase timer
	// ************************************************************
	tmc_interval_timer #(
		.WIDTH      (TMR_W)
	) tmc_interval_timer_inst (
		.core_clk   (core_clk),
		.rst_b      (rst_b),
		.load       (tmr_load),
		.load_count (tmr_count),
		.expired    (tmr_expired)
	);

	// ************************************************************
	// Outputs
	// ************************************************************
	logic res_bit;

	// Resolution bit of the channel in flight
	always_comb
	begin
		unique case (state.channel)
			tmc_pkg::TMC_CH_X:  res_bit = state.resolution[tmc_pkg::X_RESOLUTION_SELECT_BIT];
			tmc_pkg::TMC_CH_Y:  res_bit = state.resolution[tmc_pkg::Y_RESOLUTION_SELECT_BIT];
			tmc_pkg::TMC_CH_Z1: res_bit = state.resolution[tmc_pkg::Z1_RESOLUTION_SELECT_BIT];
			tmc_pkg::TMC_CH_Z2: res_bit = state.resolution[tmc_pkg::Z2_RESOLUTION_SELECT_BIT];
		endcase
	end

	// Panel drive and ADC power, acquire and convert follow the phase; resolution selects come from the register
	always_comb
	begin
		adc_ctl.panel_drive   = (state.phase != tmc_pkg::TMC_ST_IDLE) &&
			(state.phase != tmc_pkg::TMC_ST_REDUCE);
		adc_ctl.adc_powered   = (state.phase == tmc_pkg::TMC_ST_ADC_SETTLE) ||
			(state.phase == tmc_pkg::TMC_ST_ACQUIRE) ||
			(state.phase == tmc_pkg::TMC_ST_CONVERT);
		adc_ctl.adc_acquire   = (state.phase == tmc_pkg::TMC_ST_ACQUIRE);
		adc_ctl.adc_convert   = (state.phase == tmc_pkg::TMC_ST_CONVERT);
		adc_ctl.adc_eight_bit = res_bit;
		adc_ctl.adc_low_power_select =
			state.resolution[tmc_pkg::ADC_LOW_POWER_SELECT_BIT];
	end

	assign meas_busy = (state.phase != tmc_pkg::TMC_ST_IDLE);
	assign reg_rdata = state.rdata;
	assign result    = state.result;

	// ************************************************************
	// Sorted insertion and reduction
	// ************************************************************
	logic [MD-1:0][SW-1:0] inserted;
	logic [MD-1:0]         keep;
	logic [15:0]           acc;
	logic [4:0]            lo;
	logic [4:0]            hi;
	logic [2:0]            shift;

	// Insert the new sample keeping the array ascending
	always_comb
	begin
		for (int i = 0; i < MD; i++)
			keep[i] = (5'(i) < state.taken) && (state.sorted[i] <= adc_sample);
		for (int i = 0; i < MD; i++)
		begin
			if (keep[i])
				inserted[i] = state.sorted[i];
			else if (i == 0)
				inserted[i] = adc_sample;
			else if (keep[i-1])
				inserted[i] = adc_sample;
			else
				inserted[i] = state.sorted[i-1];
		end
	end

	// Window of sorted samples summed, and the divide as a shift
	always_comb
	begin
		if (state.depth_code == 2'h0)
		begin
			lo    = 5'h00;
			hi    = 5'h01;
			shift = 3'h0;
		end
		else if (state.mean_mode)
		begin
			lo    = 5'h00;
			hi    = depth_total(state.depth_code);
			shift = 3'(state.depth_code) + 3'h1;
		end
		else
		begin
			lo    = depth_total(state.depth_code) >> 2;
			hi    = depth_total(state.depth_code) - lo;
			shift = 3'(state.depth_code);
		end
		acc = 16'h0000;
		for (int i = 0; i < MD; i++)
			if ((5'(i) >= lo) && (5'(i) < hi))
				acc = acc + 16'(state.sorted[i]);
	end

	// ************************************************************
	// Sequencer and registers
	// ************************************************************
	always_comb
	begin
		next_state = state;
		tmr_load   = 1'b0;
		tmr_count  = TMR_W'(1);
		next_state.result.valid = 1'b0;

		// Register writes; unused resolution bits are dropped
		if (reg_req.write)
		begin
			unique case (reg_req.addr)
				tmc_pkg::MEASUREMENT_RESOLUTION_OFS:
					next_state.resolution = reg_req.wdata &
						tmc_pkg::RESOLUTION_IMPL_MASK;
				tmc_pkg::MEASUREMENT_AVERAGING_OFS:     next_state.averaging = reg_req.wdata;
				tmc_pkg::ADC_SAMPLING_TIME_OFS:         next_state.sampling = reg_req.wdata;
				tmc_pkg::PANEL_SETUP_TIMING_OFS:        next_state.panel_setup = reg_req.wdata;
				tmc_pkg::DELAYED_CONVERSION_TIMING_OFS: next_state.delayed_conv = reg_req.wdata;
				default: ;
			endcase
		end

		// Read data registered one cycle after the address
		unique case (reg_req.addr)
			tmc_pkg::MEASUREMENT_RESOLUTION_OFS:    next_state.rdata = state.resolution;
			tmc_pkg::MEASUREMENT_AVERAGING_OFS:     next_state.rdata = state.averaging;
			tmc_pkg::ADC_SAMPLING_TIME_OFS:         next_state.rdata = state.sampling;
			tmc_pkg::PANEL_SETUP_TIMING_OFS:        next_state.rdata = state.panel_setup;
			tmc_pkg::DELAYED_CONVERSION_TIMING_OFS: next_state.rdata = state.delayed_conv;
			default:                                next_state.rdata = tmc_pkg::UNMAPPED_READ;
		endcase

		unique case (state.phase)
			tmc_pkg::TMC_ST_IDLE:
			begin
				// Every command kind and scan enters here; channel, averaging and acquisition codes are frozen per run
				if (meas_start)
				begin
					next_state.channel    = meas_channel;
					next_state.mean_mode  = averaging_filter_select;
					next_state.depth_code = averaging_enable ?
						chan_field(state.averaging, meas_channel) : 2'h0;
					next_state.acq_code   = chan_field(state.sampling, meas_channel);
					next_state.taken      = 5'h00;
					tmr_load              = 1'b1;
					if (settle_code(state.panel_setup, meas_channel) ==
						tmc_pkg::PANEL_SKIP_CODE)
					begin
						next_state.phase = tmc_pkg::TMC_ST_ADC_SETTLE;
						tmr_count = ladder_cycles(
							settle_code(state.delayed_conv, meas_channel));
					end
					else
					begin
						next_state.phase = tmc_pkg::TMC_ST_PANEL_SETUP;
						tmr_count = ladder_cycles(
							settle_code(state.panel_setup, meas_channel));
					end
				end
			end
			tmc_pkg::TMC_ST_PANEL_SETUP:
			begin
				if (tmr_expired)
				begin
					next_state.phase = tmc_pkg::TMC_ST_ADC_SETTLE;
					tmr_load  = 1'b1;
					tmr_count = ladder_cycles(
						settle_code(state.delayed_conv, state.channel));
				end
			end
			tmc_pkg::TMC_ST_ADC_SETTLE:
			begin
				if (tmr_expired)
				begin
					next_state.phase = tmc_pkg::TMC_ST_ACQUIRE;
					tmr_load  = 1'b1;
					tmr_count = acquire_cycles(state.acq_code);
				end
			end
			tmc_pkg::TMC_ST_ACQUIRE:
			begin
				// Conversion waits for the full acquisition
				if (tmr_expired)
					next_state.phase = tmc_pkg::TMC_ST_CONVERT;
			end
			tmc_pkg::TMC_ST_CONVERT:
			begin
				if (adc_conv_done)
				begin
					next_state.sorted = inserted;
					next_state.taken  = state.taken + 5'h01;
					if (state.taken + 5'h01 >= depth_total(state.depth_code))
						next_state.phase = tmc_pkg::TMC_ST_REDUCE;
					else
					begin
						next_state.phase = tmc_pkg::TMC_ST_ACQUIRE;
						tmr_load  = 1'b1;
						tmr_count = acquire_cycles(state.acq_code);
					end
				end
			end
			tmc_pkg::TMC_ST_REDUCE:
			begin
				next_state.result.valid   = 1'b1;
				next_state.result.channel = state.channel;
				next_state.result.value   = SW'(acc >> shift);
				next_state.phase          = tmc_pkg::TMC_ST_IDLE;
			end
			default:
				next_state.phase = tmc_pkg::TMC_ST_IDLE;
		endcase
	end

	// Register the copy; all fields reset to documented defaults
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state              <= '0;
			state.phase        <= tmc_pkg::TMC_ST_IDLE;
			state.resolution   <= tmc_pkg::MEASUREMENT_RESOLUTION_RST;
			state.averaging    <= tmc_pkg::MEASUREMENT_AVERAGING_RST;
			state.sampling     <= tmc_pkg::ADC_SAMPLING_TIME_RST;
			state.panel_setup  <= tmc_pkg::PANEL_SETUP_TIMING_RST;
			state.delayed_conv <= tmc_pkg::DELAYED_CONVERSION_TIMING_RST;
		end
		else
			state <= next_state;
	end

endmodule : tmc_measure_seq

`default_nettype wire

// ==== bench/tmc_adc_model.sv ====
// ADC stand-in answering each conversion request of the sequencer.
// Assumes adc_ctl comes from the sequencer on the shared core clock.
`timescale 1ns/1ps
`default_nettype none

module tmc_adc_model #(
	parameter logic [11:0] SAMPLES [16] = '{default: 12'h000}
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst_b,
	input  wire tmc_pkg::tmc_adc_ctl_s adc_ctl,
	input  wire logic [3:0]            conv_lat,
	output logic                       adc_conv_done,
	output logic [11:0]                adc_sample
);
	logic [3:0] wait_cnt;
	logic [3:0] idx;

	// One done pulse per request after conv_lat extra cycles; data toggles
	// whenever no sample is offered, so a late capture shows up
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
		begin
			wait_cnt      <= 4'h0;
			idx           <= 4'h0;
			adc_conv_done <= 1'b0;
			adc_sample    <= 12'h000;
		end
		else
		begin
			adc_conv_done <= 1'b0;
			adc_sample    <= ~adc_sample;
			if (!adc_ctl.panel_drive)
				idx <= 4'h0;
			if (adc_ctl.adc_convert && !adc_conv_done)
			begin
				wait_cnt <= (wait_cnt == conv_lat) ? 4'h0 : wait_cnt + 4'h1;
				if (wait_cnt == conv_lat)
				begin
					adc_conv_done <= 1'b1;
					adc_sample    <= SAMPLES[idx];
					idx           <= idx + 4'h1;
				end
			end
		end
endmodule : tmc_adc_model

`default_nettype wire

// ==== bench/tmc_measure_seq_assertions.sv ====
// Port checker of the measurement sequencer.
// Assumes it is bound into every sequencer instance.
`timescale 1ns/1ps
`default_nettype none

module tmc_measure_seq_assertions #(
	parameter int unsigned CYCLES_PER_US = 10
) (
	input wire logic                         core_clk,
	input wire logic                         rst_b,
	input wire tmc_pkg::tmc_reg_req_s        reg_req,
	input wire logic [7:0]                   reg_rdata,
	input wire logic                         meas_start,
	input wire tmc_pkg::tmc_channel_e        meas_channel,
	input wire logic                         averaging_enable,
	input wire logic                         averaging_filter_select,
	input wire logic                         adc_conv_done,
	input wire logic [tmc_pkg::SAMPLE_W-1:0] adc_sample,
	input wire tmc_pkg::tmc_adc_ctl_s        adc_ctl,
	input wire logic                         meas_busy,
	input wire tmc_pkg::tmc_result_s         result
);
	// ************
	// Helpers
	// ************
	localparam int MIN_DLY = 10 * CYCLES_PER_US;
	logic [15:0] acq_cnt;
	logic [15:0] dly_cnt;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// Length of the running acquire phase
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			acq_cnt <= 16'h0000;
		else
			acq_cnt <= adc_ctl.adc_acquire ? acq_cnt + 16'h0001 : 16'h0000;

	// Powered wait before sampling, held across a run so later samples pass too
	always_ff @(posedge core_clk or negedge rst_b)
		if (!rst_b)
			dly_cnt <= 16'h0000;
		else if (!adc_ctl.adc_powered)
			dly_cnt <= 16'h0000;
		else if (!adc_ctl.adc_acquire && !adc_ctl.adc_convert)
			dly_cnt <= dly_cnt + 16'h0001;

	// ************
	// Assertions
	// ************
	AST_LOW_POWER_BIT: assert property (
		reg_req.write && reg_req.addr == 8'h02
		|=> adc_ctl.adc_low_power_select == $past(reg_req.wdata[4]))
		else $error("low power select wrong");
	AST_RES_UPPER_ZERO: assert property (
		$past(reg_req.addr) == 8'h02 |-> reg_rdata[7:5] == 3'h0)
		else $error("resolution upper bits not zero");
	AST_ACQ_LENGTH: assert property (
		$fell(adc_ctl.adc_acquire)
		|-> acq_cnt inside {16'h0014, 16'h0050, 16'h0140, 16'h0500})
		else $error("acquire length off");
	AST_ACQ_BEFORE_CONV: assert property (
		$rose(adc_ctl.adc_convert) |-> $past(adc_ctl.adc_acquire))
		else $error("convert without acquire");
	AST_CONV_HOLDS: assert property (
		adc_ctl.adc_convert && !adc_conv_done |=> adc_ctl.adc_convert)
		else $error("convert dropped early");
	AST_DELAY_MIN: assert property (
		$rose(adc_ctl.adc_acquire) |-> dly_cnt >= 16'(MIN_DLY))
		else $error("delayed conversion too short");
	AST_SETTLE_POWERED: assert property (
		adc_ctl.adc_acquire || adc_ctl.adc_convert
		|-> adc_ctl.panel_drive && adc_ctl.adc_powered)
		else $error("sampling without panel or power");
	AST_START_BUSY: assert property (
		meas_start && !meas_busy |=> meas_busy)
		else $error("start not taken");
	AST_RESULT_FOLLOWS: assert property (
		result.valid |-> $past(adc_conv_done, 2) && !meas_busy)
		else $error("result not after last conversion");
	AST_VALID_PULSE: assert property (
		result.valid |=> !result.valid)
		else $error("result valid too long");
	AST_IDLE_QUIET: assert property (
		!meas_busy |-> !adc_ctl.panel_drive && !adc_ctl.adc_powered)
		else $error("panel or ADC active while idle");

	COV_RESULT: cover property (result.valid);
	COV_LONG_ACQ: cover property ($fell(adc_ctl.adc_acquire) && acq_cnt == 16'h0500);
	COV_BUSY_START: cover property (meas_start && meas_busy);
endmodule : tmc_measure_seq_assertions

bind tmc_measure_seq tmc_measure_seq_assertions #(
	.CYCLES_PER_US(CYCLES_PER_US)
) tmc_measure_seq_assertions_inst (
	.core_clk, .rst_b, .reg_req, .reg_rdata, .meas_start, .meas_channel,
	.averaging_enable, .averaging_filter_select, .adc_conv_done, .adc_sample,
	.adc_ctl, .meas_busy, .result
);

`default_nettype wire

// ==== bench/test_tmc_measure_seq.sv ====
// Self-checking bench of the measurement sequencer with an ADC model.
// Assumes settle ladders shortened to one cycle per microsecond.
`timescale 1ns/1ps
`default_nettype none

module test_tmc_measure_seq;
	localparam int unsigned CPU = 1;
	localparam logic [11:0] SMP [16] = '{12'h0A5, 12'h3F0, 12'h011, 12'hFFE,
		12'h7C2, 12'h200, 12'h0FF, 12'h888, 12'h123, 12'hABC, 12'h456,
		12'hDEF, 12'h001, 12'h999, 12'h555, 12'hE00};
	logic                  core_clk;
	logic                  rst_b;
	tmc_pkg::tmc_reg_req_s reg_req;
	logic [7:0]            reg_rdata;
	logic                  meas_start;
	tmc_pkg::tmc_channel_e meas_channel;
	logic                  averaging_enable;
	logic                  averaging_filter_select;
	logic                  adc_conv_done;
	logic [11:0]           adc_sample;
	tmc_pkg::tmc_adc_ctl_s adc_ctl;
	logic                  meas_busy;
	tmc_pkg::tmc_result_s  result;
	logic [3:0]            conv_lat;
	int                    bad_count;
	int                    samples_checked;
	int                    cycles;

	tmc_measure_seq #(
		.CYCLES_PER_US(CPU)
	) tmc_measure_seq_inst (
		.core_clk, .rst_b, .reg_req, .reg_rdata, .meas_start, .meas_channel,
		.averaging_enable, .averaging_filter_select, .adc_conv_done, .adc_sample,
		.adc_ctl, .meas_busy, .result
	);

	tmc_adc_model #(
		.SAMPLES(SMP)
	) tmc_adc_model_inst (
		.core_clk, .rst_b, .adc_ctl, .conv_lat, .adc_conv_done, .adc_sample
	);

	// Clock and hang guard; a run this short never nears the ceiling
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			bad_count++;
			wrap_up();
		end
	end

	// ************
	// Helpers
	// ************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		reg_req = '{write: 1'b1, addr: a, wdata: d};
		@(posedge core_clk) #1;
		reg_req.write = 1'b0;
		@(posedge core_clk) #1;
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
		reg_req.addr = a;
		@(posedge core_clk) #1;
		check(reg_rdata, exp);
	endtask : reg_rd

	// Sort, trim a quarter at each end for median, divide what is left
	function automatic logic [11:0] exp_val(input int n, input logic filt);
		logic [11:0] a [16];
		int          s;
		int          lo;
		a = SMP;
		for (int i = 0; i < n; i++)
			for (int j = i + 1; j < n; j++)
				if (a[j] < a[i])
					{a[i], a[j]} = {a[j], a[i]};
		lo = filt ? 0 : n / 4;
		s = 0;
		for (int i = lo; i < n - lo; i++)
			s += a[i];
		return 12'(s / (n - 2 * lo));
	endfunction : exp_val

	// Program one channel, start, poke a refused start, then judge the result
	task automatic measure(input tmc_pkg::tmc_channel_e ch, input logic [1:0] dep,
		input logic filt, input logic en, input logic [1:0] acq,
		input logic [3:0] psu, input logic [3:0] dcv, input logic res);
		int   sh;
		int   n;
		int   k;
		int   exp_cyc;
		logic pos;
		sh = 6 - 2 * int'(ch);
		n = (dep == 2'b00 || !en) ? 1 : 2 << dep;
		pos = ch < tmc_pkg::TMC_CH_Z1;
		reg_wr(8'h02, 8'(res) << (3 - int'(ch)));
		reg_wr(8'h03, 8'(dep) << sh);
		reg_wr(8'h04, 8'(acq) << sh);
		reg_wr(8'h05, pos ? {psu, 4'h0} : {4'h0, psu});
		reg_wr(8'h06, pos ? {dcv, 4'h0} : {4'h0, dcv});
		exp_cyc = (psu == 4'h0 ? 0 : tmc_pkg::SETTLE_LADDER_US[psu] * CPU)
			+ tmc_pkg::SETTLE_LADDER_US[dcv] * CPU + 2
			+ n * (tmc_pkg::ACQ_OSC_PERIODS[acq] * tmc_pkg::CYC_PER_OSC + conv_lat + 2);
		meas_channel = ch;
		averaging_enable = en;
		averaging_filter_select = filt;
		meas_start = 1'b1;
		@(posedge core_clk) #1;
		meas_start = 1'b0;
		k = 1;
		check({adc_ctl.panel_drive, adc_ctl.adc_powered}, {1'b1, psu == 4'h0});
		while (result.valid !== 1'b1 && k < 9000)
		begin
			@(posedge core_clk) #1;
			k++;
			meas_start = (k == 5);
		end
		check(16'(k), 16'(exp_cyc));
		check(result.value, exp_val(n, filt));
		check(result.channel, ch);
		check(adc_ctl.adc_eight_bit, res);
	endtask : measure

	// ************
	// Scenarios
	// ************
	task automatic t_regs;
		for (int a = 2; a < 8; a++)
			reg_rd(8'(a), 8'h00);
		reg_wr(8'h02, 8'hFF);
		reg_rd(8'h02, 8'h1F);
		check(adc_ctl.adc_low_power_select, 1'b1);
		reg_wr(8'h02, 8'h0F);
		check(adc_ctl.adc_low_power_select, 1'b0);
		reg_wr(8'h05, 8'hA5);
		reg_rd(8'h05, 8'hA5);
	endtask : t_regs

	// Shortest panel setup, shortest delay: the cheap way to settle a panel
	task automatic t_position;
		conv_lat = 4'h0;
		measure(tmc_pkg::TMC_CH_X, 2'b00, 1'b0, 1'b1, 2'b00, 4'h1, 4'h0, 1'b0);
	endtask : t_position

	task automatic t_median;
		conv_lat = 4'h3;
		measure(tmc_pkg::TMC_CH_Y, 2'b11, 1'b0, 1'b1, 2'b01, 4'h2, 4'h1, 1'b1);
	endtask : t_median

	task automatic t_mean_skip;
		conv_lat = 4'h1;
		measure(tmc_pkg::TMC_CH_Z1, 2'b10, 1'b1, 1'b1, 2'b10, 4'h0, 4'h2, 1'b1);
	endtask : t_mean_skip

	task automatic t_gated;
		conv_lat = 4'h2;
		measure(tmc_pkg::TMC_CH_Z2, 2'b01, 1'b0, 1'b0, 2'b11, 4'h3, 4'h3, 1'b0);
	endtask : t_gated

	task automatic wrap_up;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	// Reset for 12 cycles, then run every scenario in turn
	initial
	begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		reg_req = '0;
		meas_start = 1'b0;
		meas_channel = tmc_pkg::TMC_CH_X;
		averaging_enable = 1'b1;
		averaging_filter_select = 1'b0;
		conv_lat = 4'h0;
		repeat (12) @(posedge core_clk);
		#1 rst_b = 1'b1;
		t_regs();
		t_position();
		t_median();
		t_mean_skip();
		t_gated();
		wrap_up();
	end
endmodule : test_tmc_measure_seq

`default_nettype wire
